// ===== src/fcs_sequencer.sv
// Device end: flash command sequencer with status word and array/Identity_query_command path.
//
// Operation
// - Ready flag low while auto operation runs.
// - Failed operation keeps ready low until reset.
// - Host commands only when ready; fcs_host never samples ready, and the bench issues one command while busy.
// - Busy-time commands ignored; only reset recovers.
// - Status bit 2 reports ROM type.
// - Bits 7:4 protection; protected blocks refuse writes.
// - ID data selected by address 15:14.
// - ID mode persists until read command.
// - Host spaces writes 15 clocks apart.
// - Unlock prefix AA/55 then command.
// - 0xF0 returns to read mode.
// - 0x90 plus 0x00 write gives ID.
// - 0xA0 then four ascending page words.
// - 0x80 prefix then 0x10 chip, 0x30 block.
// - 0x9A/0x6A seven-cycle protection bit operations.
// - Host keeps address bits 1:0 zero.
// - Address 15:8 code, data 7:0 command.
// - Loads only at documented cycles.
// - Host orders each store with barrier; fcs_host only spaces stores 15 clocks apart, with no barrier.
// - Host orders each ID load with barrier; fcs_host loads 15 clocks after the 0x00 write, with no barrier.
// - Host tunes write spacing via ID query; fcs_host uses the fixed FCS_WRITE_GAP_CYCLES spacing.
// - Protection erase ignores commands until done.
`timescale 1ns/1ps
module fcs_sequencer
#(
   parameter int OP_CYCLES = 64,
   parameter logic ROM_IS_MASK = 1'b0,
   parameter logic [31:0] ID_WORD0 = 32'h0000_0011,
   parameter logic [31:0] ID_WORD1 = 32'h0000_0022,
   parameter logic [31:0] ID_WORD2 = 32'h0000_0033,
   parameter logic [31:0] ID_WORD3 = 32'h0000_0044,
   parameter int ARRAY_WORDS = 64
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   fcs_bus_if.device bus,
   input wire logic op_fail,
   output logic [fcs_pkg::FCS_BLOCKS-1:0] prot_status,
   output logic ready
);
   import fcs_pkg::*;

   typedef enum logic [3:0] {
      FCS_S_READ = 4'b0000,
      FCS_S_U1 = 4'b0001,
      FCS_S_U2 = 4'b0010,
      FCS_S_ID = 4'b0011,
      FCS_S_PROG = 4'b0100,
      FCS_S_E1 = 4'b0101,
      FCS_S_E2 = 4'b0110,
      FCS_S_E3 = 4'b0111,
      FCS_S_BUSY = 4'b1000,
      FCS_S_FAIL = 4'b1001
   } fcs_state_type;

   localparam int AW = $clog2(ARRAY_WORDS);

   fcs_state_type state;
   logic [7:0] ecmd;
   logic [1:0] step;
   logic [1:0] idsel;
   logic [1:0] wcount;
   logic [15:0] op_count;
   logic start_op;
   logic [FCS_BLOCKS-1:0] prot;
   logic [FCS_BLOCKS-1:0] next_prot;
   logic [31:0] mem [ARRAY_WORDS];
   logic [AW-1:0] waddr;
   logic [1:0] blk;
   logic [7:0] code;
   logic [7:0] d8;

   function automatic logic [1:0] fcs_block(input logic [31:0] a);
      fcs_block = a[FCS_SEL_HI:FCS_SEL_LO];
   endfunction

   assign code = bus.addr[FCS_CODE_HI:FCS_CODE_LO];
   assign d8 = bus.wdata[7:0];
   assign blk = fcs_block(bus.addr);
   assign start_op = bus.wr && ((state == FCS_S_PROG && wcount == 2'(FCS_PAGE_WORDS - 1)) ||
                     (state == FCS_S_E3 && step == 2'b01 && d8 == ecmd) ||
                     (state == FCS_S_E3 && step == 2'b00 && ecmd == FCS_CMD_ERASE &&
                      ((d8 == FCS_CMD_CHIP && code == FCS_ADDR_CODE1) || d8 == FCS_CMD_BLOCK)));

   // ----------------------------------------
   // Command decoding
   // ----------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state <= FCS_S_READ;
         ecmd <= 8'h00;
         step <= 2'b00;
         wcount <= 2'b00;
         idsel <= 2'b00;
         op_count <= 16'h0000;
         next_prot <= '0;
      end
      else if (state == FCS_S_BUSY)
      begin
         // Any write here is dropped, including protection erase traffic.
         if (op_fail)
            state <= FCS_S_FAIL;
         else if (op_count == 16'(OP_CYCLES - 1))
            state <= FCS_S_READ;
         else
            op_count <= op_count + 16'h0001;
      end
      else if (bus.wr && state != FCS_S_FAIL)
      begin
         // Page data may carry any low byte, so the read command is not decoded there.
         if (d8 == FCS_CMD_READ && state != FCS_S_U2 && state != FCS_S_PROG)
            state <= FCS_S_READ;
         else
         begin
            case (state)
               FCS_S_READ:
                  if (code == FCS_ADDR_CODE1 && d8 == FCS_UNLOCK_DATA1)
                     state <= FCS_S_U1;
               FCS_S_U1:
                  if (code == FCS_ADDR_CODE2 && d8 == FCS_UNLOCK_DATA2)
                     state <= FCS_S_U2;
                  else
                     state <= FCS_S_READ;
               FCS_S_U2:
               begin
                  ecmd <= d8;
                  wcount <= 2'b00;
                  step <= 2'b00;
                  if (code != FCS_ADDR_CODE1)
                     state <= FCS_S_READ;
                  else if (d8 == FCS_CMD_READ)
                     state <= FCS_S_READ;
                  else if (d8 == FCS_CMD_ID)
                     state <= FCS_S_ID;
                  else if (d8 == FCS_CMD_PROGRAM)
                     state <= FCS_S_PROG;
                  else if (d8 == FCS_CMD_ERASE || d8 == FCS_CMD_PROT_SET ||
                           d8 == FCS_CMD_PROT_CLR)
                     state <= FCS_S_E1;
                  else
                     state <= FCS_S_READ;
               end
               FCS_S_ID:
                  if (bus.wdata[3:0] != FCS_ID_BAD_NIBBLE)
                     idsel <= blk;
               FCS_S_PROG:
               begin
                  wcount <= wcount + 2'b01;
                  if (wcount == 2'(FCS_PAGE_WORDS - 1))
                  begin
                     state <= FCS_S_BUSY;
                     op_count <= 16'h0000;
                  end
               end
               FCS_S_E1:
                  if (code == FCS_ADDR_CODE1 && d8 == FCS_UNLOCK_DATA1)
                     state <= FCS_S_E2;
                  else
                     state <= FCS_S_READ;
               FCS_S_E2:
                  if (code == FCS_ADDR_CODE2 && d8 == FCS_UNLOCK_DATA2)
                     state <= FCS_S_E3;
                  else
                     state <= FCS_S_READ;
               FCS_S_E3:
               begin
                  op_count <= 16'h0000;
                  if (start_op && step == 2'b00)
                  begin
                     state <= FCS_S_BUSY;
                     next_prot <= prot;
                  end
                  else if (step == 2'b00 && ecmd != FCS_CMD_ERASE && d8 == ecmd &&
                           code == FCS_ADDR_CODE1)
                     step <= 2'b01;
                  else if (start_op)
                  begin
                     step <= 2'b00;
                     state <= FCS_S_BUSY;
                     if (ecmd == FCS_CMD_PROT_SET)
                        next_prot <= prot | (FCS_BLOCKS'(1) << blk);
                     else if (bus.addr[FCS_SEL_HI])
                        next_prot <= prot & 4'b0011;
                     else
                        next_prot <= prot & 4'b1100;
                  end
                  else
                     state <= FCS_S_READ;
               end
               default:
                  state <= FCS_S_READ;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Array, protection and status
   // ----------------------------------------
   assign waddr = bus.addr[AW+1:2];

   always_ff @(posedge sys_clk)
   begin
      // Protected blocks silently keep their contents.
      if (rst_n && bus.wr && state == FCS_S_PROG && !prot[blk])
         mem[waddr] <= bus.wdata;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         prot <= '0;
      else if (state == FCS_S_BUSY && !op_fail && op_count == 16'(OP_CYCLES - 1))
         prot <= next_prot;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ready <= 1'b1;
         prot_status <= '0;
      end
      else
      begin
         ready <= !(state == FCS_S_BUSY || state == FCS_S_FAIL || start_op);
         prot_status <= prot;
      end
   end

   // ----------------------------------------
   // Load path
   // ----------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         bus.rvalid <= 1'b0;
         bus.rdata <= 32'h0000_0000;
      end
      else
      begin
         bus.rvalid <= bus.rd;
         if (bus.addr == FCS_STATUS_ADDR)
         begin
            bus.rdata <= 32'h0000_0000;
            bus.rdata[FCS_ST_READY] <= ready;
            bus.rdata[FCS_ST_ROMTYPE] <= ROM_IS_MASK;
            bus.rdata[FCS_ST_PROT_LO +: FCS_BLOCKS] <= prot;
         end
         else if (state == FCS_S_ID)
         begin
            case (idsel)
               2'b00: bus.rdata <= ID_WORD0;
               2'b01: bus.rdata <= ID_WORD1;
               2'b10: bus.rdata <= ID_WORD2;
               default: bus.rdata <= ID_WORD3;
            endcase
         end
         else
            bus.rdata <= mem[waddr];
      end
   end
endmodule // fcs_sequencer

// ===== src/fcs_pkg.sv
// Package of constants and types shared by both ends of the flash command sequencer.
package fcs_pkg;
   // ----------------------------------------
   // Command sequence codes
   // ----------------------------------------
   localparam logic [7:0] FCS_UNLOCK_DATA1 = 8'haa;
   localparam logic [7:0] FCS_UNLOCK_DATA2 = 8'h55;
   localparam logic [7:0] FCS_ADDR_CODE1 = 8'h55;
   localparam logic [7:0] FCS_ADDR_CODE2 = 8'haa;
   localparam logic [7:0] FCS_CMD_READ = 8'hf0;
   localparam logic [7:0] FCS_CMD_ID = 8'h90;
   localparam logic [7:0] FCS_CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] FCS_CMD_ERASE = 8'h80;
   localparam logic [7:0] FCS_CMD_CHIP = 8'h10;
   localparam logic [7:0] FCS_CMD_BLOCK = 8'h30;
   localparam logic [7:0] FCS_CMD_PROT_SET = 8'h9a;
   localparam logic [7:0] FCS_CMD_PROT_CLR = 8'h6a;
   localparam logic [7:0] FCS_ID_FOURTH_DATA = 8'h00;
   localparam logic [3:0] FCS_ID_BAD_NIBBLE = 4'hf;
   // ----------------------------------------
   // Address fields and status layout
   // ----------------------------------------
   localparam int FCS_CODE_HI = 15;
   localparam int FCS_CODE_LO = 8;
   localparam int FCS_SEL_HI = 15;
   localparam int FCS_SEL_LO = 14;
   localparam int FCS_PAGE_WORDS = 4;
   localparam int FCS_BLOCKS = 4;
   localparam int FCS_ST_READY = 0;
   localparam int FCS_ST_ROMTYPE = 2;
   localparam int FCS_ST_PROT_LO = 4;
   localparam logic [31:0] FCS_STATUS_ADDR = 32'hffff_e520;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int FCS_WRITE_GAP_CYCLES = 15;
   // ----------------------------------------
   // Host command codes
   // ----------------------------------------
   typedef enum logic [2:0] {
      FCS_OP_READ = 3'b000,
      FCS_OP_RESET = 3'b001,
      FCS_OP_ID = 3'b010,
      FCS_OP_PROGRAM = 3'b011,
      FCS_OP_CHIP_ERASE = 3'b100,
      FCS_OP_BLOCK_ERASE = 3'b101,
      FCS_OP_PROT_SET = 3'b110,
      FCS_OP_PROT_CLR = 3'b111
   } fcs_op_type;
endpackage

// ===== src/fcs_bus_if.sv
// Interface carrying CPU store and load cycles between the host and the sequencer.
`timescale 1ns/1ps
interface fcs_bus_if;
   logic wr;
   logic rd;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic rvalid;
   modport device (input wr, input rd, input addr, input wdata, output rdata, output rvalid);
   modport host (output wr, output rd, output addr, output wdata, input rdata, input rvalid);
endinterface

// ===== src/fcs_host.sv
// Host end: issues command sequences as spaced store cycles and loads.
`timescale 1ns/1ps
module fcs_host
   import fcs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   fcs_bus_if.host bus,
   input wire logic cmd_valid,
   input wire fcs_pkg::fcs_op_type cmd_op,
   input wire logic [31:0] cmd_addr,
   input wire logic [127:0] cmd_data,
   output logic cmd_ready,
   output logic [31:0] rsp_data,
   output logic rsp_valid
);
   import fcs_pkg::*;

   typedef enum logic [1:0] {
      FCS_H_IDLE = 2'b00,
      FCS_H_WRITE = 2'b01,
      FCS_H_LOAD = 2'b10,
      FCS_H_WAIT = 2'b11
   } fcs_host_state_type;

   fcs_host_state_type state;
   fcs_op_type op;
   logic [31:0] base;
   logic [127:0] page;
   logic [2:0] idx;
   logic [2:0] last;
   logic [4:0] gap;

   function automatic logic [2:0] fcs_last_cycle(input fcs_op_type o);
      case (o)
         FCS_OP_READ: fcs_last_cycle = 3'd0;
         FCS_OP_RESET: fcs_last_cycle = 3'd2;
         FCS_OP_ID: fcs_last_cycle = 3'd3;
         FCS_OP_CHIP_ERASE: fcs_last_cycle = 3'd5;
         FCS_OP_BLOCK_ERASE: fcs_last_cycle = 3'd5;
         default: fcs_last_cycle = 3'd6;
      endcase
   endfunction

   function automatic logic [7:0] fcs_code(input logic [2:0] i);
      fcs_code = (i == 3'd1 || i == 3'd4) ? FCS_ADDR_CODE2 : FCS_ADDR_CODE1;
   endfunction

   function automatic logic [7:0] fcs_cmd(input fcs_op_type o);
      case (o)
         FCS_OP_RESET: fcs_cmd = FCS_CMD_READ;
         FCS_OP_ID: fcs_cmd = FCS_CMD_ID;
         FCS_OP_PROGRAM: fcs_cmd = FCS_CMD_PROGRAM;
         FCS_OP_PROT_SET: fcs_cmd = FCS_CMD_PROT_SET;
         FCS_OP_PROT_CLR: fcs_cmd = FCS_CMD_PROT_CLR;
         default: fcs_cmd = FCS_CMD_ERASE;
      endcase
   endfunction

   // ----------------------------------------
   // Sequence driver
   // ----------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state <= FCS_H_IDLE;
         op <= FCS_OP_READ;
         base <= 32'h0000_0000;
         page <= '0;
         idx <= 3'd0;
         last <= 3'd0;
         gap <= 5'd0;
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
         bus.addr <= 32'h0000_0000;
         bus.wdata <= 32'h0000_0000;
         cmd_ready <= 1'b1;
         rsp_data <= 32'h0000_0000;
         rsp_valid <= 1'b0;
      end
      else
      begin
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
         rsp_valid <= 1'b0;
         case (state)
            FCS_H_IDLE:
               if (cmd_valid)
               begin
                  op <= cmd_op;
                  base <= {cmd_addr[31:2], 2'b00};
                  page <= cmd_data;
                  idx <= 3'd0;
                  last <= fcs_last_cycle(cmd_op);
                  gap <= 5'd0;
                  cmd_ready <= 1'b0;
                  state <= FCS_H_WRITE;
               end
            FCS_H_WRITE:
               if (gap != 5'd0)
                  gap <= gap - 5'd1;
               else
               begin
                  bus.wr <= 1'b1;
                  gap <= 5'(FCS_WRITE_GAP_CYCLES - 1);
                  bus.addr <= {base[31:16], fcs_code(idx), 8'h00};
                  if (op == FCS_OP_READ)
                     bus.wdata <= {24'h0, FCS_CMD_READ};
                  else if (idx == 3'd0 || idx == 3'd3)
                     bus.wdata <= {24'h0, FCS_UNLOCK_DATA1};
                  else if (idx == 3'd1 || idx == 3'd4)
                     bus.wdata <= {24'h0, FCS_UNLOCK_DATA2};
                  else
                     bus.wdata <= {24'h0, fcs_cmd(op)};
                  if (op == FCS_OP_ID && idx == 3'd3)
                  begin
                     bus.addr <= {base[31:2], 2'b00};
                     bus.wdata <= {24'h0, FCS_ID_FOURTH_DATA};
                  end
                  if (op == FCS_OP_PROGRAM && idx >= 3'd3)
                  begin
                     bus.addr <= {base[31:4], 2'(idx - 3'd3), 2'b00};
                     bus.wdata <= page[32 * (idx - 3'd3) +: 32];
                  end
                  if (op == FCS_OP_BLOCK_ERASE && idx == 3'd5)
                  begin
                     bus.addr <= {base[31:2], 2'b00};
                     bus.wdata <= {24'h0, FCS_CMD_BLOCK};
                  end
                  if (op == FCS_OP_CHIP_ERASE && idx == 3'd5)
                     bus.wdata <= {24'h0, FCS_CMD_CHIP};
                  if ((op == FCS_OP_PROT_SET || op == FCS_OP_PROT_CLR) && idx == 3'd6)
                     bus.addr <= {base[31:2], 2'b00};
                  if (idx == last)
                     state <= (op == FCS_OP_READ || op == FCS_OP_RESET || op == FCS_OP_ID)
                              ? FCS_H_LOAD : FCS_H_WAIT;
                  idx <= idx + 3'd1;
               end
            FCS_H_LOAD:
               if (gap != 5'd0)
                  gap <= gap - 5'd1;
               else
               begin
                  bus.rd <= 1'b1;
                  bus.addr <= {base[31:2], 2'b00};
                  state <= FCS_H_WAIT;
               end
            default:
               if (bus.rvalid)
               begin
                  rsp_data <= bus.rdata;
                  rsp_valid <= 1'b1;
                  cmd_ready <= 1'b1;
                  state <= FCS_H_IDLE;
               end
               else if (!(op == FCS_OP_READ || op == FCS_OP_RESET || op == FCS_OP_ID) &&
                        gap == 5'd0)
               begin
                  cmd_ready <= 1'b1;
                  state <= FCS_H_IDLE;
               end
               else if (gap != 5'd0)
                  gap <= gap - 5'd1;
         endcase
      end
   end
endmodule // fcs_host

// ===== tb/fcs_assertions.sv
// Concurrent checks on the bus that joins the host end to the sequencer end.
`timescale 1ns/1ps
module fcs_assertions
#(
   parameter logic ROM_IS_MASK = 1'b0
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic op_fail,
   input wire logic [fcs_pkg::FCS_BLOCKS-1:0] prot_status,
   input wire logic ready
);
   import fcs_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // Store spacing counter
   // ----------------------------------------
   // Saturates so that a long idle period never wraps into a false short gap.
   logic [4:0] gap_cnt;
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         gap_cnt <= 5'h1f;
      else if (wr)
         gap_cnt <= 5'h01;
      else if (gap_cnt != 5'h1f)
         gap_cnt <= gap_cnt + 5'h01;
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   store_gap_a: assert property (wr |-> gap_cnt >= 5'h0f)
      else $error("stores closer than the minimum spacing");
   load_answer_a: assert property (rd |=> rvalid)
      else $error("load not answered in the next cycle");
   answer_cause_a: assert property (rvalid |-> $past(rd))
      else $error("load answer without a load");
   addr_align_a: assert property ((wr || rd) |-> addr[1:0] == 2'b00)
      else $error("bus address low bits not zero");
   busy_start_a: assert property ($fell(ready) |-> $past(wr))
      else $error("ready dropped without a store");
   fail_hold_a: assert property ((!ready && op_fail) |=> !ready)
      else $error("ready rose after a failed operation");
   reset_state_a: assert property ($rose(rst_n) |-> ready && !rvalid && prot_status == 4'h0)
      else $error("state after reset not ready and idle");
   status_word_a: assert property ((rvalid && ready && $past(ready) && addr == FCS_STATUS_ADDR)
      |-> rdata == {24'h0, prot_status, 1'b0, ROM_IS_MASK, 1'b0, 1'b1})
      else $error("status word does not match flags");
   prot_change_a: assert property ($changed(prot_status) |-> !$past(ready))
      else $error("protection changed outside an operation");
endmodule // fcs_assertions

// ===== tb/test_flash_command_sequencer.sv
// Self-checking bench joining the host end and the sequencer end.
`timescale 1ns/1ps
module test_flash_command_sequencer;
   import fcs_pkg::*;
   typedef struct {
      fcs_op_type op;
      logic [31:0] addr;
      logic [127:0] data;
      logic has_rsp;
      logic [31:0] exp;
   } fcs_row_type;
   // Busy length is long enough that a second command can land inside it.
   localparam int OPC = 40;
   localparam int NROWS = 19;
   // Identity words are arbitrary values.
   localparam logic [31:0] ID0 = 32'h0000_00a1;
   localparam logic [31:0] ID1 = 32'h0000_00b2;
   localparam logic [31:0] ID2 = 32'h0000_00c3;
   localparam logic [31:0] ID3 = 32'h0000_00d4;
   localparam logic [127:0] PG = 128'h4444_4444_3333_3333_2222_2222_1111_1111;
   localparam logic [127:0] PG2 = 128'h8888_8888_7777_7777_6666_6666_5555_5555;
   logic sys_clk;
   logic rst_n;
   logic op_fail;
   logic cmd_valid;
   logic cmd_ready;
   logic rsp_valid;
   fcs_op_type cmd_op;
   logic [31:0] cmd_addr;
   logic [31:0] rsp_data;
   logic [127:0] cmd_data;
   logic [3:0] prot_status;
   logic ready;
   int err_total;
   int total_checks;
   fcs_row_type rows [NROWS] = '{
      '{FCS_OP_PROGRAM, 32'h0000_0010, PG, 1'b0, 32'h0},
      '{FCS_OP_READ, 32'h0000_0010, 128'h0, 1'b1, 32'h1111_1111},
      '{FCS_OP_READ, 32'h0000_0014, 128'h0, 1'b1, 32'h2222_2222},
      '{FCS_OP_READ, 32'h0000_001c, 128'h0, 1'b1, 32'h4444_4444},
      '{FCS_OP_PROGRAM, 32'h0000_8020, PG2, 1'b0, 32'h0},
      '{FCS_OP_PROT_SET, 32'h0000_8000, 128'h0, 1'b0, 32'h0},
      '{FCS_OP_READ, FCS_STATUS_ADDR, 128'h0, 1'b1, 32'h0000_0041},
      '{FCS_OP_PROGRAM, 32'h0000_8020, PG, 1'b0, 32'h0},
      '{FCS_OP_READ, 32'h0000_8020, 128'h0, 1'b1, 32'h5555_5555},
      '{FCS_OP_PROT_CLR, 32'h0000_8000, 128'h0, 1'b0, 32'h0},
      '{FCS_OP_READ, FCS_STATUS_ADDR, 128'h0, 1'b1, 32'h0000_0001},
      '{FCS_OP_ID, 32'h0000_0000, 128'h0, 1'b1, ID0},
      '{FCS_OP_ID, 32'h0000_4000, 128'h0, 1'b1, ID1},
      '{FCS_OP_ID, 32'h0000_8000, 128'h0, 1'b1, ID2},
      '{FCS_OP_ID, 32'h0000_c000, 128'h0, 1'b1, ID3},
      '{FCS_OP_RESET, 32'h0000_0014, 128'h0, 1'b1, 32'h2222_2222},
      '{FCS_OP_BLOCK_ERASE, 32'h0000_4000, 128'h0, 1'b0, 32'h0},
      '{FCS_OP_CHIP_ERASE, 32'h0000_0000, 128'h0, 1'b0, 32'h0},
      '{FCS_OP_READ, FCS_STATUS_ADDR, 128'h0, 1'b1, 32'h0000_0001}
   };
   fcs_bus_if bus_if();
   fcs_sequencer #(.OP_CYCLES(OPC), .ID_WORD0(ID0), .ID_WORD1(ID1), .ID_WORD2(ID2),
      .ID_WORD3(ID3), .ARRAY_WORDS(16384)) i_fcs_sequencer (.sys_clk(sys_clk),
      .rst_n(rst_n), .bus(bus_if), .op_fail(op_fail), .prot_status(prot_status), .ready(ready));
   fcs_host i_fcs_host (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_if), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .rsp_data(rsp_data), .rsp_valid(rsp_valid));
   fcs_assertions #(.ROM_IS_MASK(1'b0)) i_fcs_assertions (.sys_clk(sys_clk), .rst_n(rst_n),
      .wr(bus_if.wr), .rd(bus_if.rd), .addr(bus_if.addr), .wdata(bus_if.wdata),
      .rdata(bus_if.rdata), .rvalid(bus_if.rvalid), .op_fail(op_fail),
      .prot_status(prot_status), .ready(ready));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic tally_and_finish;
      if (err_total == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk1(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic wait_idle(input logic need_ready);
      for (int n = 0; n < 600; n++)
      begin
         @(posedge sys_clk);
         if (cmd_ready === 1'b1 && (ready === 1'b1 || !need_ready))
            return;
      end
      err_total++;
      $display("[ERR] idle wait expected 1 seen 0");
      tally_and_finish();
   endtask
   task automatic issue(input fcs_op_type op, input logic [31:0] a, input logic [127:0] d);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
   endtask
   task automatic run_row(input fcs_row_type r);
      wait_idle(1'b1);
      issue(r.op, r.addr, r.data);
      if (!r.has_rsp)
      begin
         wait_idle(1'b1);
         return;
      end
      for (int n = 0; n < 600; n++)
      begin
         @(posedge sys_clk);
         if (rsp_valid === 1'b1)
         begin
            chk32(r.op.name(), r.exp, rsp_data);
            return;
         end
      end
      chk1("response", 1'b1, 1'b0);
      tally_and_finish();
   endtask
   task automatic pulse_reset;
      rst_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
   endtask
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial
   begin
      rst_n = 1'b0;
      op_fail = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = FCS_OP_READ;
      cmd_addr = 32'h0;
      cmd_data = 128'h0;
      err_total = 0;
      total_checks = 0;
      pulse_reset();
      for (int i = 0; i < NROWS; i++)
         run_row(rows[i]);
      // A command landing in a busy period must not take effect.
      wait_idle(1'b1);
      issue(FCS_OP_CHIP_ERASE, 32'h0, 128'h0);
      wait_idle(1'b0);
      chk1("ready while busy", 1'b0, ready);
      issue(FCS_OP_PROT_SET, 32'h0000_4000, 128'h0);
      wait_idle(1'b1);
      run_row('{FCS_OP_READ, FCS_STATUS_ADDR, 128'h0, 1'b1, 32'h0000_0001});
      // A failed operation holds busy until a hardware reset.
      op_fail <= 1'b1;
      issue(FCS_OP_PROGRAM, 32'h0000_0040, PG);
      wait_idle(1'b0);
      op_fail <= 1'b0;
      repeat (60) @(posedge sys_clk);
      chk1("ready after failure", 1'b0, ready);
      pulse_reset();
      @(posedge sys_clk);
      chk1("ready after reset", 1'b1, ready);
      run_row('{FCS_OP_READ, FCS_STATUS_ADDR, 128'h0, 1'b1, 32'h0000_0001});
      tally_and_finish();
   end
endmodule // test_flash_command_sequencer
